/* File: verilog/wom_pkg.sv */
// Package for the motion wake controller: settings, codes, states.
// Assumes one 100 MHz clock shared by both ends.
package wom_pkg;
    localparam int MODE_W = 2;
    localparam int CODE_W = 8;
    localparam int SAMPLE_W = 16;
    localparam int AXES = 3;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_HOST = 2'h1;
    localparam logic [1:0] MODE_RX = 2'h2;
    localparam logic [1:0] MODE_BOTH = 2'h3;
    localparam logic [1:0] MODE_RESET = 2'h0;
    localparam logic [7:0] CODE_RESET = 8'h00;
    localparam logic [7:0] CODE_ZERO_G = 8'h01;
    localparam logic [7:0] CODE_ONE_G = 8'hFF;
    localparam logic [7:0] CODE_HALF_G = 8'h80;
    // Sample scale: counts per one g
    localparam logic [15:0] ONE_G_COUNTS = 16'h4000;
    localparam int ALERT_NS = 1000;
    localparam int CLK_NS = 10;
    localparam int ALERT_CYC = (ALERT_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [1:0] {
        WOM_AWAKE = 2'b00,
        WOM_SLEEP = 2'b01,
        WOM_WAKE = 2'b11
    } wom_pwr_e;
endpackage : wom_pkg

/* File: verilog/wom_link_if.sv */
// Interface joining the host end and the receiver end.
// Assumes both ends share clk and rst.
`timescale 1ns/1ps
interface wom_link_if;
    logic [1:0] mode;
    logic [7:0] code;
    logic cfg_valid;
    logic power_cycle;
    logic sleep_req;
    logic [31:0] sleep_duration;
    logic extint0_en;
    logic motion_alert_pin;
    logic rx_awake;
    modport dev (
        input mode, code, cfg_valid, power_cycle, sleep_req,
        input sleep_duration, extint0_en,
        output motion_alert_pin, rx_awake
    );
    modport host (
        output mode, code, cfg_valid, power_cycle, sleep_req,
        output sleep_duration, extint0_en,
        input motion_alert_pin, rx_awake
    );
endinterface : wom_link_if

/* File: verilog/wom_dev.sv */
// Receiver end: holds motion wake settings, compares sensor samples,
// drives the alert pin and the receiver wake path.
// Assumes samples arrive synchronous to clk with a one-cycle valid.
//
// Contract
// RULE1: Mode resets to zero, feature off.
// RULE2: Mode 1 pulses alert pin, no wake.
// RULE3: Mode 2 wakes receiver, no pin.
// RULE4: Mode 3 wakes receiver and pulses pin.
// RULE5: Woken receiver resumes normal operation.
// RULE6: Codes 1..255 map linearly zero to 1g.
// RULE7: Threshold resets to 0, meaning half g.
// RULE8: One threshold, any axis exceeding fires.
// RULE9: Host selects host-only mode only.
// RULE10: Host stores settings before sending them.
// RULE11: Power cycle after change arms sensor.
// RULE12: Host requests backup sleep, duration zero.
// RULE13: Host keeps external int0 wake enabled.
// RULE14: Asleep receiver relies on sensor interrupt.
// RULE15: Absolute axis value compared each sample.
`timescale 1ns/1ps
module wom_dev (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link to host
    wom_link_if.dev link,
    // Sensor side
    input wire logic sample_valid,
    input wire logic [wom_pkg::AXES*wom_pkg::SAMPLE_W-1:0] sample,
    output logic sensor_armed,
    output logic motion_event
);
    import wom_pkg::*;

    logic [1:0] mode_reg;
    logic [1:0] pend_mode_reg;
    logic [7:0] pend_code_reg;
    logic [15:0] thr_reg;
    logic armed_reg;
    logic [AXES-1:0] over;
    logic hit;
    logic pin_hit;
    logic wake_hit;
    logic alert_reg;
    logic [7:0] alert_cnt_reg;
    wom_pwr_e pwr_reg;
    logic event_reg;

    ////////////////////////////////////////////////////////////////////////
    // Code to counts; code 0 means half g
    function automatic logic [15:0] code_to_thr(input logic [7:0] c);
        logic [23:0] p;
        p = 24'h000000;
        if (c == CODE_RESET) begin
            p = {9'h000, ONE_G_COUNTS[15:1]}; // see RULE7
        end else begin
            p = ({16'h0000, c - CODE_ZERO_G} * {8'h00, ONE_G_COUNTS})
                / 24'(CODE_ONE_G - CODE_ZERO_G); // see RULE6
        end
        return p[15:0];
    endfunction : code_to_thr

    // Modes that drive the alert pin toward the host
    function automatic logic mode_has_pin(input logic [1:0] m);
        return (m == MODE_HOST) || (m == MODE_BOTH);
    endfunction : mode_has_pin

    // Modes in which motion may end the backup sleep
    function automatic logic mode_has_wake(input logic [1:0] m);
        return (m == MODE_RX) || (m == MODE_BOTH);
    endfunction : mode_has_wake

    ////////////////////////////////////////////////////////////////////////
    // Settings: new values wait for the power cycle to take effect,
    // so a mode and a code sent together always go live together
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_mode_reg <= MODE_RESET;
        end else if (link.cfg_valid) begin
            pend_mode_reg <= link.mode;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_code_reg <= CODE_RESET;
        end else if (link.cfg_valid) begin
            pend_code_reg <= link.code;
        end
    end

    // Applied mode; the alert and wake decodes read only this copy
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mode_reg <= MODE_RESET; // see RULE1
        end else if (link.power_cycle) begin
            mode_reg <= pend_mode_reg; // see RULE11
        end
    end

    // Divider sits on the power-cycle path only, never per sample
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            thr_reg <= {1'b0, ONE_G_COUNTS[15:1]}; // see RULE7
        end else if (link.power_cycle) begin
            thr_reg <= code_to_thr(pend_code_reg); // see RULE6
        end
    end

    // Armed only for a mode that does something on motion
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            armed_reg <= 1'b0; // see RULE1
        end else if (link.power_cycle) begin
            armed_reg <= mode_has_pin(pend_mode_reg) ||
                mode_has_wake(pend_mode_reg); // see RULE11
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-axis magnitude compare; full-scale negative reads as 0x8000,
    // above any threshold, so it cannot alias to a small magnitude
    genvar g;
    generate
        for (g = 0; g < AXES; g++) begin : g_axis
            logic signed [15:0] s;
            logic [15:0] mag;
            assign s = sample[g*SAMPLE_W +: SAMPLE_W];
            assign mag = s[15] ? 16'(-s) : s; // see RULE15
            assign over[g] = mag > thr_reg;
        end
    endgenerate

    // Any axis above the shared threshold
    assign hit = sample_valid && armed_reg && (|over); // see RULE8
    assign pin_hit = hit && mode_has_pin(mode_reg); // see RULE2 see RULE4
    assign wake_hit = hit && link.extint0_en && mode_has_wake(mode_reg);

    // Registered so the sensor side sees a clean one-cycle pulse
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            event_reg <= 1'b0;
        end else begin
            event_reg <= hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alert pin: fixed-width pulse so a slow host can catch it; a new hit
    // restarts the count, so steady shaking holds the pin high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alert_cnt_reg <= 8'h00;
        end else if (pin_hit) begin
            alert_cnt_reg <= 8'(ALERT_CYC - 1);
        end else if (alert_cnt_reg != 8'h00) begin
            alert_cnt_reg <= alert_cnt_reg - 8'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alert_reg <= 1'b0;
        end else if (pin_hit) begin
            alert_reg <= 1'b1; // see RULE2 see RULE4
        end else if (alert_cnt_reg == 8'h00) begin
            alert_reg <= 1'b0; // see RULE1 see RULE3
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receiver power state; only sensor interrupt wakes it while asleep.
    // Host-only mode leaves it asleep until the next reset.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pwr_reg <= WOM_AWAKE;
        end else begin
            unique case (pwr_reg)
                WOM_AWAKE: begin
                    if (link.sleep_req && link.sleep_duration == 32'h0)
                    begin
                        pwr_reg <= WOM_SLEEP; // see RULE12
                    end
                end
                WOM_SLEEP: begin
                    if (wake_hit) begin
                        pwr_reg <= WOM_WAKE; // see RULE3 see RULE4 see RULE14
                    end
                end
                WOM_WAKE: begin
                    pwr_reg <= WOM_AWAKE; // see RULE5
                end
                default: begin
                    pwr_reg <= WOM_AWAKE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign link.motion_alert_pin = alert_reg;
    assign link.rx_awake = (pwr_reg == WOM_AWAKE);
    assign sensor_armed = armed_reg;
    assign motion_event = event_reg;
endmodule : wom_dev

/* File: verilog/wom_host.sv */
// Host end: sends settings, power cycles, requests backup sleep,
// and reports the alert pin to its user.
// Assumes user commands are one-cycle pulses on clk.
`timescale 1ns/1ps
module wom_host (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // User side
    input wire logic cfg_start,
    input wire logic [wom_pkg::CODE_W-1:0] cfg_code,
    input wire logic sleep_start,
    output logic busy,
    output logic alert_seen,
    output logic rx_awake_out,
    // Link to device
    wom_link_if.host link
);
    import wom_pkg::*;

    typedef enum logic [1:0] {
        WH_IDLE = 2'b00,
        WH_SEND = 2'b01,
        WH_CYCLE = 2'b11,
        WH_SLEEP = 2'b10
    } wh_state_e;

    wh_state_e st_reg;
    logic [7:0] code_reg;
    logic alert_reg;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= WH_IDLE;
            code_reg <= CODE_RESET;
        end else begin
            unique case (st_reg)
                WH_IDLE: begin
                    if (cfg_start) begin
                        code_reg <= cfg_code; // see RULE10
                        st_reg <= WH_SEND;
                    end else if (sleep_start) begin
                        st_reg <= WH_SLEEP;
                    end
                end
                WH_SEND: st_reg <= WH_CYCLE;
                WH_CYCLE: st_reg <= WH_IDLE; // see RULE11
                WH_SLEEP: st_reg <= WH_IDLE;
            endcase
        end
    end

    // Alert is sticky toward the user; a new sleep request clears it only while the pin is low
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            alert_reg <= 1'b0;
        end else if (link.motion_alert_pin) begin
            alert_reg <= 1'b1;
        end else if (st_reg == WH_SLEEP) begin
            alert_reg <= 1'b0;
        end
    end

    assign link.mode = MODE_HOST; // see RULE9
    assign link.code = code_reg;
    assign link.cfg_valid = (st_reg == WH_SEND);
    assign link.power_cycle = (st_reg == WH_CYCLE);
    assign link.sleep_req = (st_reg == WH_SLEEP);
    assign link.sleep_duration = 32'h00000000; // see RULE12
    assign link.extint0_en = 1'b1; // see RULE13
    assign busy = (st_reg != WH_IDLE);
    assign alert_seen = alert_reg;
    assign rx_awake_out = link.rx_awake;
endmodule : wom_host

/* File: testbench/wom_link_monitor.sv */
// Checker for the motion wake link between host end and receiver end.
// Assumes one clock; sits beside the interface, no bind.
`timescale 1ns/1ps
module wom_link_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Host to receiver
    input wire logic [1:0] mode,
    input wire logic [7:0] code,
    input wire logic cfg_valid,
    input wire logic power_cycle,
    input wire logic sleep_req,
    input wire logic [31:0] sleep_duration,
    input wire logic extint0_en,
    // Receiver to host
    input wire logic motion_alert_pin,
    input wire logic rx_awake
);
    import wom_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // Saturating run length, so a stuck pin cannot wrap and look short
    logic [7:0] high_cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) high_cnt <= 8'h00;
        else if (!motion_alert_pin) high_cnt <= 8'h00;
        else if (high_cnt != 8'hFF) high_cnt <= high_cnt + 8'h01;
    end
    ////////////////////////////////////////////////////////////////////////
    sequence s_arm;
        cfg_valid ##1 power_cycle;
    endsequence
    sequence s_sleep;
        sleep_req ##1 !rx_awake;
    endsequence
    chk_mode_host_only: assert property (mode == MODE_HOST)
        else $error("mode other than host only");
    chk_sleep_dur_zero: assert property
        (sleep_req |-> sleep_duration == 32'h0)
        else $error("sleep request with nonzero duration");
    chk_int0_kept_on: assert property (sleep_req |-> extint0_en)
        else $error("sleep request without int0 wake");
    chk_cfg_then_cycle: assert property
        (cfg_valid |-> s_arm)
        else $error("power cycle missing after settings");
    chk_sleep_enters: assert property (sleep_req |-> s_sleep)
        else $error("receiver still awake after sleep request");
    chk_no_rx_wake: assert property
        ((mode == MODE_HOST && !rx_awake && !power_cycle) |=> !rx_awake)
        else $error("receiver woke in host only mode");
    chk_pin_by_mode: assert property
        ($rose(motion_alert_pin) |-> mode[0])
        else $error("alert pin in a mode without pin");
    chk_pin_width: assert property
        ($fell(motion_alert_pin) |-> high_cnt >= ALERT_CYC)
        else $error("alert pulse too short");
endmodule : wom_link_monitor

/* File: testbench/wake_on_motion_ctrl_tb.sv */
// Testbench joining host end and receiver end across the link.
// Assumes settings in wom_pkg; inputs driven at falling clock edge.
`timescale 1ns/1ps
module wake_on_motion_ctrl_tb;
    import wom_pkg::*;
    logic clk, rst, cfg_start, sleep_start, sample_valid;
    logic [7:0] cfg_code;
    logic [47:0] sample;
    logic busy, alert_seen, rx_awake_out, sensor_armed, motion_event;
    logic [15:0] sv;
    logic [7:0] codes [4] = '{8'h00, 8'h01, 8'h40, 8'hFF};
    int fail_count, checked, thr;
    wom_link_if link ();
    wom_host u_wom_host (.clk(clk), .rst(rst), .cfg_start(cfg_start),
        .cfg_code(cfg_code), .sleep_start(sleep_start), .busy(busy),
        .alert_seen(alert_seen), .rx_awake_out(rx_awake_out), .link(link));
    wom_dev u_wom_dev (.clk(clk), .rst(rst), .link(link),
        .sample_valid(sample_valid), .sample(sample),
        .sensor_armed(sensor_armed), .motion_event(motion_event));
    wom_link_monitor u_wom_link_monitor (.clk(clk), .rst(rst),
        .mode(link.mode), .code(link.code), .cfg_valid(link.cfg_valid),
        .power_cycle(link.power_cycle), .sleep_req(link.sleep_req),
        .sleep_duration(link.sleep_duration), .extint0_en(link.extint0_en),
        .motion_alert_pin(link.motion_alert_pin), .rx_awake(link.rx_awake));
    ////////////////////////////////////////////////////////////////////////
    task cmp(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : cmp
    task end_sim;
        if (fail_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim
    task configure(input logic [7:0] c);
        @(negedge clk) cfg_code = c;
        cfg_start = 1'b1;
        @(negedge clk) cfg_start = 1'b0;
        repeat (4) @(negedge clk);
        cmp(busy, 1'b0);
        cmp(sensor_armed, 1'b1);
    endtask : configure
    task go_sleep;
        @(negedge clk) sleep_start = 1'b1;
        @(negedge clk) sleep_start = 1'b0;
        repeat (3) @(negedge clk);
        cmp(rx_awake_out, 1'b0);
        cmp(alert_seen, 1'b0);
    endtask : go_sleep
    // One valid sample on one axis, the other axes at zero
    task feed(input int axis, input logic [15:0] v, input logic exp);
        logic [47:0] axes_word;
        axes_word = 48'h0;
        axes_word[axis*16 +: 16] = v;
        @(negedge clk) sample = axes_word;
        sample_valid = 1'b1;
        @(negedge clk) sample_valid = 1'b0;
        cmp(motion_event, exp);
        @(negedge clk);
        cmp(link.motion_alert_pin, exp);
    endtask : feed
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #20us;
        fail_count++;
        end_sim();
    end
    initial begin
        rst = 1'b1;
        {cfg_start, sleep_start, sample_valid} = 3'h0;
        cfg_code = 8'h00;
        sample = 48'h0;
        fail_count = 0;
        checked = 0;
        repeat (20) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        cmp(link.motion_alert_pin, 1'b0);
        cmp(rx_awake_out, 1'b1);
        cmp(sensor_armed, 1'b0);
        cmp(alert_seen, 1'b0);
        feed(0, 16'h7FFF, 1'b0);
        // Each code: at threshold stays quiet, one count above fires
        for (int i = 0; i < 4; i++) begin
            thr = (codes[i] == 8'h00) ? 32'h2000
                : (int'(codes[i]) - 1) * 32'h4000 / 254;
            configure(codes[i]);
            go_sleep();
            sv = (i % 2) ? 16'(-thr) : 16'(thr);
            feed(i % 3, sv, 1'b0);
            sv = (i % 2) ? 16'(-(thr + 1)) : 16'(thr + 1);
            feed(i % 3, sv, 1'b1);
            cmp(rx_awake_out, 1'b0);
            cmp(alert_seen, 1'b1);
            // Let the pulse end so the next quiet sample shows a low pin
            repeat (ALERT_CYC + 10) @(negedge clk);
            cmp(link.motion_alert_pin, 1'b0);
        end
        end_sim();
    end
endmodule : wake_on_motion_ctrl_tb
